/* hw/sar_adc_sequencer.sv */
// Notes on behaviour
// RQ1: Channel code picks input 0-7, references, midpoint or test; 8-11 reserved.
// RQ2: First two clocks connect mux to capacitor, next two amplifier charges array.
// RQ3: Third phase connects input directly for 2, 4, 8 or 16 clocks.
// RQ4: Sample period equals extension clocks plus four.
// RQ5: Approximation bits resolved one at a time from MSB to LSB.
// RQ6: Writing setup register aborts and halts until sequence control written.
// RQ7: Writing sequence control aborts and starts a new sequence.
// RQ8: Abort by control write clears sequence and conversion done flags.
// RQ9: Five-bit modulus divider by 2..32 then divide by two; code zero reserved.
// RQ10: Divider field resets to divide-by-eight code.
// RQ11: Converter clock spans at least four system clocks.
// RQ12: Software keeps converter clock between 0.5 and 2.1 MHz.
// RQ13: Resolution bit selects 8 or 10 bits, results aligned automatically.
// RQ14: Eight-conversion bit selects four or eight conversions per sequence.
// RQ15: Scan bit selects one sequence or continuous sequences.
// RQ16: Multi-channel bit selects one channel or block of channels.
// RQ17: Each finished conversion is copied into its own result register.
// RQ18: Status shows sequence done, current channel, conversion done flags.
// RQ19: Done flag per filled result; sequence flag after first sequence.
// RQ20: Multi-channel runs consecutive channels from the selected one.
// RQ21: Stop bit set on reset gates converter clock and aborts conversion.
// RQ22: Freeze response: ignore, finish then freeze, or freeze at once.
// RQ23: One converter clock per result bit during resolution.
`timescale 1ns/1ns
`default_nettype none
module sar_adc_sequencer
    import adc_seq_pkg::*;
(
    input  wire logic                     clk_sys,      // System clock
    input  wire logic                     rst,          // Sync reset, high
    input  wire logic                     clk_en,       // Freezes all state
    input  wire logic                     psel,         // APB select
    input  wire logic                     penable,      // APB enable
    input  wire logic                     pwrite,       // APB direction
    input  wire logic [7:0]               paddr,        // APB byte address
    input  wire logic [31:0]              pwdata,       // APB write data
    output logic      [31:0]              prdata,       // APB read data
    output logic                          pready,       // APB ready
    output logic                          pslverr,      // APB error
    input  wire logic                     freeze,       // Debug freeze
    input  wire logic                     comparator,   // High: input above DAC
    output adc_seq_pkg::mux_sel_t         mux_sel,      // Source select
    output adc_seq_pkg::sample_sw_t       sample_sw,    // Sample switches
    output logic      [9:0]               dac_code,     // Trial code
    output logic                          conv_clk      // Converter clock
);
    import adc_seq_pkg::*;

    typedef enum logic [1:0] {IDLE, SAMPLE, RESOLVE} state_t;

    ////////////////////////////////////////////////////////////////////////
    // Registers and bus decode
    logic [4:0]  div_reg;
    logic [1:0]  ext_reg;
    logic        res_reg;
    logic [3:0]  chan_reg;
    logic        multi_reg, eight_reg, scan_reg;
    logic        stop_reg;
    logic [1:0]  frz_reg;
    logic        seq_done_reg;
    logic [7:0]  conv_done_reg;
    logic [9:0]  result_reg [8];

    wire bus_wr     = psel && penable && pwrite;
    wire wr_setup   = bus_wr && paddr == SETUP_ADDR;
    wire wr_seqctl  = bus_wr && paddr == SEQCTL_ADDR;
    wire wr_modcfg  = bus_wr && paddr == MODCFG_ADDR;
    wire is_result  = paddr[7:5] == RESULT_ADDR[7:5] && paddr[1:0] == 2'b00;
    wire [2:0] rsel = paddr[4:2];
    wire mapped     = paddr == SETUP_ADDR || paddr == SEQCTL_ADDR
                   || paddr == STATUS_ADDR || paddr == MODCFG_ADDR
                   || is_result;

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer state
    state_t      state_reg;
    logic [4:0]  phase_cnt_reg;
    logic [1:0]  phase_reg;
    logic [3:0]  bit_reg;
    logic [9:0]  sar_reg;
    logic [2:0]  conv_idx_reg;
    logic [3:0]  cur_chan_reg;
    logic        first_seq_reg;
    logic        frozen_reg;

    // RQ1: channel decode
    function automatic mux_sel_t decode_chan(input logic [3:0] c);
        mux_sel_t m;
        m.input_index = c[2:0];
        if (!c[3])
            m.kind = SRC_INPUT;
        else if (!c[2])
            m.kind = SRC_NONE;
        else
            unique case (c[1:0])
                2'b00: m.kind = SRC_HIGH_REF;
                2'b01: m.kind = SRC_LOW_REF;
                2'b10: m.kind = SRC_MID_REF;
                2'b11: m.kind = SRC_TEST;
            endcase
        return m;
    endfunction : decode_chan

    assign mux_sel = decode_chan(cur_chan_reg);

    ////////////////////////////////////////////////////////////////////////
    // Prescaler
    // RQ9: modulus counter then toggle
    logic [4:0] presc_cnt_reg;
    logic       conv_clk_reg;
    wire        running  = state_reg != IDLE;
    // RQ21: stop gates the converter clock
    wire        clk_gate = !stop_reg && !frozen_reg && running;
    // RQ11: code zero treated as one keeps divide >= 4
    wire [4:0]  div_eff  = (div_reg == 5'd0) ? 5'd1 : div_reg;
    wire        presc_wrap = presc_cnt_reg >= div_eff;
    // Tick on falling converter clock edge so every phase spans whole clocks
    wire        tick = clk_gate && presc_wrap && conv_clk_reg;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            presc_cnt_reg <= 5'd0;
            conv_clk_reg  <= 1'b0;
        end
        else if (clk_en)
        begin
            if (!clk_gate || presc_wrap)
                presc_cnt_reg <= 5'd0;
            else
                presc_cnt_reg <= presc_cnt_reg + 5'd1;
            if (!clk_gate)
                conv_clk_reg <= 1'b0;
            else if (presc_wrap)
                conv_clk_reg <= !conv_clk_reg;
        end
    end
    assign conv_clk = conv_clk_reg;

    ////////////////////////////////////////////////////////////////////////
    // Phase lengths
    // RQ3: third phase length
    wire [4:0] ext_clocks = 5'd2 << ext_reg;
    // RQ4: total sample period is ext plus four
    wire [4:0] phase_len = (phase_reg == 2'd0) ? PHASE1_CLOCKS
                         : (phase_reg == 2'd1) ? PHASE2_CLOCKS : ext_clocks;
    wire       phase_end = phase_cnt_reg == phase_len - 5'd1;
    // RQ23: eight or ten resolve clocks
    wire [3:0] msb      = res_reg ? 4'd9 : 4'd7;
    wire       conv_end = state_reg == RESOLVE && bit_reg == 4'd0 && tick;
    wire [2:0] last_idx = eight_reg ? 3'd7 : 3'd3;
    wire       seq_end  = conv_end && conv_idx_reg == last_idx;
    wire [9:0] sar_bit  = 10'd1 << bit_reg;
    wire [9:0] sar_set  = comparator ? sar_reg : (sar_reg & ~sar_bit);
    wire [9:0] final_sar = sar_set;
    // RQ13: left-justify 8-bit result into 10-bit field
    wire [9:0] aligned  = res_reg ? final_sar : {final_sar[7:0], 2'b00};
    // RQ20: next channel in block
    wire [3:0] next_chan = multi_reg
        ? {chan_reg[3:3], chan_reg[2:0] + conv_idx_reg + 3'd1}
        : chan_reg;
    wire       abort = wr_setup || wr_seqctl || stop_reg;

    // RQ22: freeze control
    wire frz_req = freeze && (frz_reg == FRZ_NOW
                || (frz_reg == FRZ_FINISH && (state_reg == IDLE
                    || (state_reg == SAMPLE && phase_reg == 2'd0
                        && phase_cnt_reg == 5'd0))));

    ////////////////////////////////////////////////////////////////////////
    // Register writes
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            // RQ10: divide-by-eight reset code
            div_reg   <= DIV_RESET;
            ext_reg   <= EXT_RESET;
            res_reg   <= 1'b0;
            chan_reg  <= 4'h0;
            multi_reg <= 1'b0;
            eight_reg <= 1'b0;
            scan_reg  <= 1'b0;
            // RQ21: stop set on reset
            stop_reg  <= 1'b1;
            frz_reg   <= FRZ_IGNORE;
            frozen_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            frozen_reg <= frz_req;
            if (wr_setup)
            begin
                div_reg <= pwdata[DIV_LSB +: 5];
                ext_reg <= pwdata[EXT_LSB +: 2];
                res_reg <= pwdata[RES_BIT];
            end
            if (wr_seqctl)
            begin
                chan_reg  <= pwdata[CHAN_LSB +: 4];
                multi_reg <= pwdata[MULTI_BIT];
                eight_reg <= pwdata[EIGHT_BIT];
                scan_reg  <= pwdata[SCAN_BIT];
            end
            if (wr_modcfg)
            begin
                stop_reg <= pwdata[STOP_BIT];
                frz_reg  <= pwdata[FRZ_LSB +: 2];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state_reg     <= IDLE;
            phase_reg     <= 2'd0;
            phase_cnt_reg <= 5'd0;
            bit_reg       <= 4'd0;
            sar_reg       <= 10'd0;
            conv_idx_reg  <= 3'd0;
            cur_chan_reg  <= 4'h0;
            first_seq_reg <= 1'b1;
            seq_done_reg  <= 1'b0;
            conv_done_reg <= 8'h00;
        end
        else if (clk_en)
        begin
            if (abort)
            begin
                // RQ8: abort clears done flags
                seq_done_reg  <= 1'b0;
                conv_done_reg <= 8'h00;
                phase_reg     <= 2'd0;
                phase_cnt_reg <= 5'd0;
                conv_idx_reg  <= 3'd0;
                first_seq_reg <= 1'b1;
                // RQ7: seqctl write restarts; RQ6: setup write halts
                if (wr_seqctl && !wr_setup && !stop_reg)
                begin
                    state_reg    <= SAMPLE;
                    cur_chan_reg <= pwdata[CHAN_LSB +: 4];
                end
                else
                    state_reg <= IDLE;
            end
            else if (tick)
            begin
                unique case (state_reg)
                    IDLE:
                    begin
                        state_reg <= IDLE;
                    end
                    // RQ2: sample phases in order
                    SAMPLE:
                    begin
                        if (!phase_end)
                            phase_cnt_reg <= phase_cnt_reg + 5'd1;
                        else if (phase_reg != 2'd2)
                        begin
                            phase_cnt_reg <= 5'd0;
                            phase_reg     <= phase_reg + 2'd1;
                        end
                        else
                        begin
                            state_reg <= RESOLVE;
                            bit_reg   <= msb;
                            sar_reg   <= 10'd1 << msb;
                        end
                    end
                    // RQ5: MSB to LSB trial bits
                    RESOLVE:
                    begin
                        if (bit_reg != 4'd0)
                        begin
                            sar_reg <= sar_set | (sar_bit >> 1);
                            bit_reg <= bit_reg - 4'd1;
                        end
                        else
                        begin
                            // RQ17: store result
                            result_reg[conv_idx_reg] <= aligned;
                            // RQ19: per-result done flag
                            conv_done_reg[conv_idx_reg] <= 1'b1;
                            phase_reg     <= 2'd0;
                            phase_cnt_reg <= 5'd0;
                            // RQ16: single vs block
                            cur_chan_reg  <= next_chan;
                            conv_idx_reg  <= conv_idx_reg + 3'd1;
                            state_reg     <= SAMPLE;
                            if (seq_end)
                            begin
                                // RQ14: sequence length
                                conv_idx_reg  <= 3'd0;
                                cur_chan_reg  <= chan_reg;
                                first_seq_reg <= 1'b0;
                                if (first_seq_reg)
                                    seq_done_reg <= 1'b1;
                                // RQ15: single or continuous
                                if (!scan_reg)
                                    state_reg <= IDLE;
                            end
                        end
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Switch and DAC outputs
    assign sample_sw.mux_to_cap      = state_reg == SAMPLE && phase_reg == 2'd0;
    assign sample_sw.amp_to_array    = state_reg == SAMPLE && phase_reg == 2'd1;
    assign sample_sw.direct_to_array = state_reg == SAMPLE && phase_reg == 2'd2;
    assign dac_code = sar_reg;

    // RQ18: status read layout
    // Sequence flag at bit 7, clear of the conversion flags
    wire [31:0] status_word = {16'h0000, conv_done_reg, seq_done_reg,
                               2'b00, running, cur_chan_reg[3:0]};
    wire [31:0] rd_mux =
        (paddr == SETUP_ADDR)  ? {24'h00_0000, res_reg, ext_reg, div_reg} :
        (paddr == SEQCTL_ADDR) ? {25'h000_0000, scan_reg, eight_reg,
                                  multi_reg, chan_reg} :
        (paddr == STATUS_ADDR) ? status_word :
        (paddr == MODCFG_ADDR) ? {29'h0000_0000, frz_reg, stop_reg} :
        is_result              ? {22'h00_0000, result_reg[rsel]} :
                                 32'h0000_0000;
    assign prdata = (psel && !pwrite) ? rd_mux : 32'h0000_0000;

endmodule : sar_adc_sequencer
`default_nettype wire

/* hw/adc_seq_pkg.sv */
package adc_seq_pkg;

    // APB byte addresses
    localparam logic [7:0]  SETUP_ADDR     = 8'h00;
    localparam logic [7:0]  SEQCTL_ADDR    = 8'h04;
    localparam logic [7:0]  STATUS_ADDR    = 8'h08;
    localparam logic [7:0]  MODCFG_ADDR    = 8'h0C;
    localparam logic [7:0]  RESULT_ADDR    = 8'h20;

    // Setup register fields
    localparam int          DIV_LSB        = 0;
    localparam int          EXT_LSB        = 5;
    localparam int          RES_BIT        = 7;
    localparam logic [4:0]  DIV_RESET      = 5'h03;
    localparam logic [1:0]  EXT_RESET      = 2'h0;

    // Sequence control fields
    localparam int          CHAN_LSB       = 0;
    localparam int          MULTI_BIT      = 4;
    localparam int          EIGHT_BIT      = 5;
    localparam int          SCAN_BIT       = 6;

    // Module configuration fields
    localparam int          STOP_BIT       = 0;
    localparam int          FRZ_LSB        = 1;

    // Sample phases in converter clocks; midpoint reference channel code
    localparam logic [4:0]  PHASE1_CLOCKS  = 5'd2;
    localparam logic [4:0]  PHASE2_CLOCKS  = 5'd2;
    localparam logic [3:0]  CHAN_MID_REF   = 4'hE;

    typedef enum logic [1:0] {
        FRZ_IGNORE = 2'b00,
        FRZ_RSVD   = 2'b01,
        FRZ_FINISH = 2'b10,
        FRZ_NOW    = 2'b11
    } freeze_mode_t;

    typedef enum logic [2:0] {
        SRC_INPUT,
        SRC_HIGH_REF,
        SRC_LOW_REF,
        SRC_MID_REF,
        SRC_TEST,
        SRC_NONE
    } source_kind_t;

    typedef struct packed {
        logic [2:0]   input_index;
        source_kind_t kind;
    } mux_sel_t;

    typedef struct packed {
        logic mux_to_cap;
        logic amp_to_array;
        logic direct_to_array;
    } sample_sw_t;

endpackage : adc_seq_pkg

/* dv/sar_adc_sequencer_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module sar_adc_sequencer_asserts
    import adc_seq_pkg::*;
(
    input wire logic                    clk_sys,   // Clock
    input wire logic                    rst,       // Reset
    input wire logic                    psel,      // Select
    input wire logic                    penable,   // Enable
    input wire logic                    pwrite,    // Direction
    input wire logic                    freeze,    // Debug freeze
    input wire adc_seq_pkg::mux_sel_t   mux_sel,   // Source
    input wire adc_seq_pkg::sample_sw_t sample_sw, // Switches
    input wire logic [9:0]              dac_code,  // Trial code
    input wire logic                    conv_clk   // Converter clock
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Control writes may cut any phase short
    wire wr = psel && penable && pwrite;
    sequence s_cap_end;
        $fell(sample_sw.mux_to_cap) && !$past(wr);
    endsequence
    sequence s_amp_end;
        $fell(sample_sw.amp_to_array) && !$past(wr);
    endsequence
    sequence s_dir_end;
        $fell(sample_sw.direct_to_array) && !$past(wr) && !freeze;
    endsequence
    ////////////////////////////////////////////////////////////////
    reset_idle_a: assert property
        ($fell(rst) |-> !conv_clk && sample_sw == '0)
        else $error("busy after reset");
    conv_gap_a: assert property
        ($rose(conv_clk) |=> !$rose(conv_clk) [*3])
        else $error("converter clock too fast");
    conv_high_a: assert property
        ($rose(conv_clk) && !wr && !freeze |=> conv_clk)
        else $error("converter clock pulse too short");
    sw_onehot_a: assert property ($onehot0(sample_sw))
        else $error("two sample switches closed");
    cap_to_amp_a: assert property (s_cap_end |-> sample_sw.amp_to_array)
        else $error("amplifier phase skipped");
    amp_to_dir_a: assert property
        (s_amp_end |-> sample_sw.direct_to_array)
        else $error("direct phase skipped");
    msb_first_a: assert property
        (s_dir_end |-> ##[0:2] $onehot(dac_code))
        else $error("first trial not a single bit");
    mux_hold_a: assert property
        (sample_sw != '0 && $past(sample_sw) != '0 && !$past(wr)
            |-> $stable(mux_sel))
        else $error("source changed while sampling");
    cover property (s_dir_end);
endmodule : sar_adc_sequencer_asserts
bind sar_adc_sequencer sar_adc_sequencer_asserts i_sar_adc_sequencer_asserts
(
    .clk_sys(clk_sys),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .freeze(freeze),
    .mux_sel(mux_sel),
    .sample_sw(sample_sw),
    .dac_code(dac_code),
    .conv_clk(conv_clk)
);
`default_nettype wire

/* dv/analog_front_model.sv */
`timescale 1ns/1ns
`default_nettype none
module analog_front_model
    import adc_seq_pkg::*;
#(
    parameter logic [9:0] STEP = 10'h07B,
    parameter logic [9:0] TEST_LEVEL = 10'h155
)
(
    input  wire logic                    clk_sys,    // Clock
    input  wire adc_seq_pkg::mux_sel_t   mux_sel,    // Source
    input  wire adc_seq_pkg::sample_sw_t sample_sw,  // Switches
    input  wire logic [9:0]              dac_code,   // Trial code
    output logic                         comparator  // Input above DAC
);
    logic [9:0] src_level;
    logic [9:0] held = 10'h000;
    always_comb
    begin
        case (mux_sel.kind)
            SRC_INPUT:    src_level = 10'(STEP * (mux_sel.input_index + 1));
            SRC_HIGH_REF: src_level = 10'h3FF;
            SRC_LOW_REF:  src_level = 10'h000;
            SRC_MID_REF:  src_level = 10'h200;
            default:      src_level = TEST_LEVEL;
        endcase
    end
    // Array holds whatever the last sample phase left
    always_ff @(posedge clk_sys)
        if (sample_sw != '0)
            held <= src_level;
    assign comparator = held >= dac_code;
endmodule : analog_front_model
`default_nettype wire

/* dv/tb_sar_adc_sequencer.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_sar_adc_sequencer;
    import adc_seq_pkg::*;
    localparam logic [9:0] STEP = 10'h07B;
    logic         clk_sys = 1'b0;
    logic         rst = 1'b1;
    logic         clk_en = 1'b1;
    logic         psel = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite = 1'b0;
    logic         freeze = 1'b0;
    logic [7:0]   paddr = 8'h00;
    logic [31:0]  pwdata = 32'h0000_0000;
    logic [31:0]  prdata;
    logic [31:0]  rd;
    logic         pready;
    logic         pslverr;
    logic         rd_err;
    logic         comparator;
    logic         conv_clk;
    logic [9:0]   dac_code;
    mux_sel_t     mux_sel;
    sample_sw_t   sample_sw;
    source_kind_t ek;
    int           err_total = 0;
    int           compares = 0;
    int           r;
    int           n[3] = '{0, 0, 0};
    freeze_mode_t fc[3] = '{FRZ_IGNORE, FRZ_FINISH, FRZ_NOW};
    sar_adc_sequencer i_sar_adc_sequencer
    (
        .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .freeze(freeze), .comparator(comparator), .mux_sel(mux_sel),
        .sample_sw(sample_sw), .dac_code(dac_code), .conv_clk(conv_clk)
    );
    analog_front_model #(.STEP(STEP)) i_analog_front_model
    (
        .clk_sys(clk_sys), .mux_sel(mux_sel), .sample_sw(sample_sw),
        .dac_code(dac_code), .comparator(comparator)
    );
    initial
        forever #25 clk_sys = ~clk_sys;
    // Phase lengths of the sampling since the last write
    always @(posedge clk_sys)
    begin
        if (psel && penable && pwrite)
            n <= '{0, 0, 0};
        else
        begin
            n[0] <= n[0] + int'(sample_sw.mux_to_cap);
            n[1] <= n[1] + int'(sample_sw.amp_to_array);
            n[2] <= n[2] + int'(sample_sw.direct_to_array);
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
            @(posedge clk_sys);
        while (pready !== 1'b1);
        rd = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb
    task automatic count_rises(input int cycles, output int k);
        logic prev;
        prev = conv_clk;
        k = 0;
        repeat (cycles)
        begin
            @(posedge clk_sys);
            k += int'(conv_clk && !prev);
            prev = conv_clk;
        end
    endtask : count_rises
    task automatic wait_seq(input logic [31:0] mask, input logic scan);
        for (int i = 0; i < 200; i++)
        begin
            apb(1'b0, STATUS_ADDR, 32'h0);
            if ((rd & mask) == mask && (scan || rd[4] === 1'b0))
                break;
            repeat (8) @(posedge clk_sys);
        end
    endtask : wait_seq
    function automatic logic [9:0] lvl(input int k);
        return 10'(STEP * (k + 1));
    endfunction : lvl
    ////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        apb(1'b0, SETUP_ADDR, 32'h0);
        check(32'(rd[4:0]), 32'(DIV_RESET));
        apb(1'b0, MODCFG_ADDR, 32'h0);
        check(32'(rd[0]), 32'h1);
        apb(1'b0, STATUS_ADDR, 32'h0);
        check(32'(rd[15:8]), 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        check(32'(rd_err), 32'h1);
        apb(1'b1, SEQCTL_ADDR, 32'h0);
        count_rises(64, r);
        check(r, 0);
        apb(1'b1, MODCFG_ADDR, 32'h0);
        // code 4 gives a 2 MHz converter clock
        apb(1'b1, SETUP_ADDR, 32'h0000_0004);
        apb(1'b1, SEQCTL_ADDR, 32'h0);
        count_rises(100, r);
        check(r, 10);
        for (int c = 0; c < 16; c++)
        begin
            apb(1'b1, SEQCTL_ADDR, 32'(c));
            repeat (2) @(posedge clk_sys);
            ek = c < 8 ? SRC_INPUT : c == 12 ? SRC_HIGH_REF :
                 c == 13 ? SRC_LOW_REF : c == 14 ? SRC_MID_REF : SRC_TEST;
            if (c < 8 || c > 11)
                check(32'(mux_sel.kind), 32'(ek));
            else
                check(32'(mux_sel.kind), 32'(SRC_NONE));
            if (c < 8)
                check(32'(mux_sel.input_index), 32'(c));
        end
        $display("divider and channel test done");
        for (int e = 0; e < 4; e++)
        begin
            apb(1'b1, SETUP_ADDR, {24'h0, e != 3, 2'(e), 5'd4});
            apb(1'b1, SEQCTL_ADDR, 32'h0000_000C);
            do
                @(posedge clk_sys);
            while (n[2] == 0 || sample_sw.direct_to_array === 1'b1);
            check(n[0], 20);
            check(n[1], 20);
            check(n[2], 20 << e);
            check(n[0] + n[1] + n[2], 10 * (4 + (2 << e)));
        end
        wait_seq(32'h0000_0F80, 1'b0);
        for (int k = 0; k < 4; k++)
        begin
            apb(1'b0, 8'(RESULT_ADDR + 4 * k), 32'h0);
            check(rd, 32'h0000_03FC);
        end
        $display("sample time test done");
        apb(1'b1, SETUP_ADDR, 32'h0000_0084);
        for (int m = 0; m < 8; m++)
        begin
            apb(1'b1, SEQCTL_ADDR,
                {25'h0, m[2], m[0], m[1], m[1] ? 4'h0 : 4'(m)});
            wait_seq(m[0] ? 32'h0000_FF80 : 32'h0000_0F80, m[2]);
            check(32'(rd[15:8]), m[0] ? 32'hFF : 32'h0F);
            check(32'(rd[7]), 32'h1);
            check(32'(rd[4]), 32'(m[2]));
            for (int k = 0; k < (m[0] ? 8 : 4); k++)
            begin
                apb(1'b0, 8'(RESULT_ADDR + 4 * k), 32'h0);
                check(rd, 32'(lvl(m[1] ? k : m)));
            end
        end
        $display("mode test done");
        apb(1'b1, SEQCTL_ADDR, 32'h0);
        wait_seq(32'h0000_0100, 1'b1);
        apb(1'b1, SEQCTL_ADDR, 32'h0);
        apb(1'b0, STATUS_ADDR, 32'h0);
        check(32'(rd[15:8]), 32'h0);
        check(32'(rd[4]), 32'h1);
        wait_seq(32'h0000_0100, 1'b1);
        apb(1'b1, SETUP_ADDR, 32'h0000_0084);
        apb(1'b0, STATUS_ADDR, 32'h0);
        check(32'(rd[15:8]), 32'h0);
        check(32'(rd[4]), 32'h0);
        $display("abort test done");
        for (int f = 0; f < 3; f++)
        begin
            apb(1'b1, MODCFG_ADDR, 32'(fc[f]) << 1);
            apb(1'b1, SEQCTL_ADDR, 32'h0000_0040);
            repeat (20) @(posedge clk_sys);
            freeze <= 1'b1;
            repeat (f == 1 ? 200 : 2) @(posedge clk_sys);
            count_rises(100, r);
            check(r, f == 0 ? 10 : 0);
            freeze <= 1'b0;
        end
        count_rises(100, r);
        check(r, 10);
        $display("freeze test done");
        test_done();
    end
    // Whole run needs about 11000 cycles
    initial
    begin
        repeat (60000) @(posedge clk_sys);
        err_total++;
        test_done();
    end
endmodule : tb_sar_adc_sequencer
`default_nettype wire
